// file: logic/ident_block.sv
// Identification data block of a packet-command device, Wishbone slave.
// Assumes a classic Wishbone master on clk_i; one wait state per access.
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ident_block
   import ident_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic bcl_abort_o,
   output logic [15:0] bcl_eff_o
);
   import ident_pkg::*;

   logic [31:0] cfg_r;
   logic [31:0] cap_r;
   logic [31:0] dma_r;
   logic [31:0] time_r;
   logic [15:0] sec_r;
   logic [15:0] bcl_r;
   logic [15:0] host_bcl_r;
   logic [7:0] ptr_r;
   logic ptr_wrap_r;
   logic [31:0] rd_nxt;
   logic [31:0] wmask;
   logic req;
   logic serial;
   logic dmadir;
   logic [15:0] w0;
   logic [15:0] w49;
   logic [15:0] w62;
   logic [15:0] w63;
   logic [15:0] w88;
   logic [15:0] w75;
   logic [15:0] w127;
   logic [4:0] ptype;
   logic [1:0] resp;
   logic [1:0] psize;
   logic [2:0] mw_sup;
   logic [2:0] mw_sel;
   logic [6:0] u_sup;
   logic [6:0] u_sel;
   logic queue;

   ident_rd_if rd ();

   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   genvar b;
   generate
      for (b = 0; b < 4; b = b + 1)
      begin : g_lane
         assign wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   endgenerate

   // Reserved codes fall back to a safe legal value rather than leak out
   always_comb
   begin
      ptype = cfg_r[CF_PTYPE +: 5];
      if (ptype >= PT_RSV_LO && ptype != PT_UNKNOWN)
      begin
         ptype = PT_UNKNOWN;
      end
      resp = cfg_r[CF_RESP +: 2];
      if (resp == RT_RSV || resp == 2'b01)
      begin
         resp = RT_3MS;
      end
      psize = cfg_r[CF_PSIZE +: 2];
      if (psize != PS_16)
      begin
         psize = PS_12;
      end
   end

   assign serial = cfg_r[CF_SERIAL];
   assign dmadir = cfg_r[CF_DMADIR];

   always_comb
   begin
      w0 = 16'h0000;
      w0[15] = 1'b1;
      w0[14] = 1'b0;
      w0[12:8] = ptype;
      w0[7] = cfg_r[CF_REMOV];
      w0[6:5] = resp;
      w0[2] = cfg_r[CF_INCOMP];
      w0[1:0] = psize;
   end

   assign queue = cap_r[CP_QUEUE];

   always_comb
   begin
      w49 = 16'h0000;
      w49[15] = cap_r[CP_INTLV] && !dmadir;
      w49[14] = queue;
      w49[13] = cap_r[CP_OVLP] || queue;
      w49[11] = cap_r[CP_IORDY] || cap_r[CP_PIO3] || serial;
      w49[10] = cap_r[CP_IODIS] || serial;
      w49[9] = 1'b1;
      w49[8] = cap_r[CP_DMA] && !dmadir;
   end

   always_comb
   begin
      w62 = 16'h0000;
      if (dmadir)
      begin
         w62[15] = 1'b1;
         w62[10:1] = 10'h3ff;
      end
      // Otherwise every bit stays zero
   end

   // Multiword support bits are filled downward so a higher mode implies lower ones; Ultra support bits pass as written except when dmadir zeroes both sets
   always_comb
   begin
      mw_sup = dma_r[DM_MWSUP +: 3];
      if (serial)
      begin
         mw_sup = 3'b111;
      end
      if (mw_sup[2])
      begin
         mw_sup[1:0] = 2'b11;
      end
      if (mw_sup[1])
      begin
         mw_sup[0] = 1'b1;
      end
      if (dmadir)
      begin
         mw_sup = 3'b000;
      end
      u_sup = dmadir ? 7'h00 : dma_r[DM_USUP +: 7];
      mw_sel = 3'b000;
      u_sel = 7'h00;
      // Lowest requested mode wins; Ultra takes priority over multiword
      for (int i = 6; i >= 0; i--)
      begin
         if (dma_r[DM_USEL + i])
         begin
            u_sel = 7'(1 << i);
         end
      end
      if (u_sel == 7'h00)
      begin
         for (int j = 2; j >= 0; j--)
         begin
            if (dma_r[DM_MWSEL + j])
            begin
               mw_sel = 3'(1 << j);
            end
         end
      end
      w63 = {5'h00, mw_sel, 5'h00, mw_sup};
      w88 = {1'b0, u_sel, 1'b0, u_sup};
   end

   // Reserved upper bits of words 75 and 127 are held at zero
   always_comb
   begin
      w75 = 16'h0000;
      w75[4:0] = cap_r[CP_QDEP +: 5];
      w127 = 16'h0000;
      if (cfg_r[CF_RMSN])
      begin
         w127[1:0] = RMSN_YES;
      end
   end

   ident_word_mux u_mux (
      .rd(rd.rsp),
      .w0_i(w0),
      .w49_i(w49),
      .w62_i(w62),
      .w63_i(w63),
      .w71_i(time_r[15:0]),
      .w72_i(time_r[31:16]),
      .w75_i(w75),
      .w88_i(w88),
      .w125_i(bcl_r),
      .w127_i(w127),
      .w128_i(sec_r)
   );

   // Serial number words read zero; no serial storage is provided
   assign rd.idx = ptr_r;

   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      unique case (wb_adr_i)
         REG_CFG: rd_nxt = cfg_r;
         REG_CAP: rd_nxt = cap_r;
         REG_DMA: rd_nxt = dma_r;
         REG_TIME: rd_nxt = time_r;
         REG_SEC: rd_nxt = {16'h0000, sec_r};
         REG_BCL: rd_nxt = {host_bcl_r, bcl_r};
         REG_PTR: rd_nxt = {23'h000000, ptr_wrap_r, ptr_r};
         REG_DATA: rd_nxt = {16'h0000, rd.word};
         REG_STAT: rd_nxt = {w88, w63};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // Ack high masks req, so a held strobe is not taken in the ack cycle, only again the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_nxt : 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cfg_r <= CFG_RST;
         cap_r <= CAP_RST;
         dma_r <= DMA_RST;
         time_r <= TIME_RST;
         sec_r <= SEC_RST;
      end
      else if (req && wb_we_i)
      begin
         unique case (wb_adr_i)
            REG_CFG: cfg_r <= (cfg_r & ~wmask) | (wb_dat_i & wmask);
            REG_CAP: cap_r <= (cap_r & ~wmask) | (wb_dat_i & wmask);
            REG_DMA: dma_r <= (dma_r & ~wmask) | (wb_dat_i & wmask);
            REG_TIME: time_r <= (time_r & ~wmask) | (wb_dat_i & wmask);
            REG_SEC: sec_r <= (sec_r & ~wmask[15:0])
               | (wb_dat_i[15:0] & wmask[15:0]);
            default:
            begin
            end
         endcase
      end
   end

   // Word 125 may change only once per reset so a reading host sees it fixed
   logic bcl_locked_r;
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bcl_r <= BCL_RST;
         host_bcl_r <= 16'h0000;
         bcl_locked_r <= 1'b0;
      end
      else if (req && wb_we_i && wb_adr_i == REG_BCL)
      begin
         if (wb_sel_i[1:0] != 2'b00 && !bcl_locked_r)
         begin
            bcl_r <= wb_dat_i[15:0];
            bcl_locked_r <= 1'b1;
         end
         if (wb_sel_i[3:2] != 2'b00)
         begin
            host_bcl_r <= wb_dat_i[31:16];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         bcl_abort_o <= 1'b0;
         bcl_eff_o <= 16'h0000;
      end
      else
      begin
         bcl_abort_o <= (host_bcl_r == 16'h0000)
            && (bcl_r == 16'h0000);
         bcl_eff_o <= (host_bcl_r == 16'h0000) ? bcl_r : host_bcl_r;
      end
   end

   // Pointer steps up after each data read, giving ascending order
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ptr_r <= 8'h00;
         ptr_wrap_r <= 1'b0;
      end
      else if (req && wb_we_i && wb_adr_i == REG_PTR && wb_sel_i[0])
      begin
         ptr_r <= wb_dat_i[7:0];
         ptr_wrap_r <= 1'b0;
      end
      else if (req && !wb_we_i && wb_adr_i == REG_DATA)
      begin
         ptr_r <= ptr_r + 8'h01;
         if (ptr_r == 8'hff)
         begin
            ptr_wrap_r <= 1'b1;
         end
      end
   end
endmodule : ident_block
`default_nettype wire

// file: logic/ident_pkg.sv
// Package: word indices, field positions and reset values for the
// packet-device identification block.
// Assumes a single 20 MHz clock domain and a 32-bit classic Wishbone bus.
package ident_pkg;
   localparam int unsigned NUM_WORDS = 256;
   // Wishbone register byte offsets
   localparam logic [7:0] REG_CFG = 8'h00;
   localparam logic [7:0] REG_CAP = 8'h04;
   localparam logic [7:0] REG_DMA = 8'h08;
   localparam logic [7:0] REG_TIME = 8'h0c;
   localparam logic [7:0] REG_SEC = 8'h10;
   localparam logic [7:0] REG_BCL = 8'h14;
   localparam logic [7:0] REG_PTR = 8'h18;
   localparam logic [7:0] REG_DATA = 8'h1c;
   localparam logic [7:0] REG_STAT = 8'h20;
   // Word indices
   localparam logic [7:0] W_GENCFG = 8'd0;
   localparam logic [7:0] W_SER_LO = 8'd10;
   localparam logic [7:0] W_SER_HI = 8'd19;
   localparam logic [7:0] W_CAPS = 8'd49;
   localparam logic [7:0] W_DMADIR = 8'd62;
   localparam logic [7:0] W_MWDMA = 8'd63;
   localparam logic [7:0] W_PKT_REL = 8'd71;
   localparam logic [7:0] W_SVC_REL = 8'd72;
   localparam logic [7:0] W_QDEPTH = 8'd75;
   localparam logic [7:0] W_UDMA = 8'd88;
   localparam logic [7:0] W_BCL0 = 8'd125;
   localparam logic [7:0] W_RMSN = 8'd127;
   localparam logic [7:0] W_SECST = 8'd128;
   // Peripheral type codes
   localparam logic [4:0] PT_DIRECT = 5'h00;
   localparam logic [4:0] PT_CDROM = 5'h05;
   localparam logic [4:0] PT_RSV_LO = 5'h10;
   localparam logic [4:0] PT_UNKNOWN = 5'h1f;
   // Response time, packet size and word 127 status codes
   localparam logic [1:0] RT_3MS = 2'b00;
   localparam logic [1:0] RT_50US = 2'b10;
   localparam logic [1:0] RT_RSV = 2'b11;
   localparam logic [1:0] PS_12 = 2'b00;
   localparam logic [1:0] PS_16 = 2'b01;
   localparam logic [1:0] RMSN_YES = 2'b01;
   // Config register field positions
   localparam int unsigned CF_PTYPE = 0;
   localparam int unsigned CF_REMOV = 5;
   localparam int unsigned CF_RESP = 6;
   localparam int unsigned CF_INCOMP = 8;
   localparam int unsigned CF_PSIZE = 9;
   localparam int unsigned CF_SERNUM = 11;
   localparam int unsigned CF_SERIAL = 12;
   localparam int unsigned CF_DMADIR = 13;
   localparam int unsigned CF_RMSN = 14;
   // Capability register field positions
   localparam int unsigned CP_INTLV = 0;
   localparam int unsigned CP_QUEUE = 1;
   localparam int unsigned CP_OVLP = 2;
   localparam int unsigned CP_PIO3 = 3;
   localparam int unsigned CP_IORDY = 4;
   localparam int unsigned CP_IODIS = 5;
   localparam int unsigned CP_DMA = 6;
   localparam int unsigned CP_QDEP = 8;
   // DMA register field positions
   localparam int unsigned DM_MWSUP = 0;
   localparam int unsigned DM_MWSEL = 4;
   localparam int unsigned DM_USUP = 8;
   localparam int unsigned DM_USEL = 16;
   // Reset values
   localparam logic [31:0] CFG_RST = 32'h0000_0000;
   localparam logic [31:0] CAP_RST = 32'h0000_0000;
   localparam logic [31:0] DMA_RST = 32'h0000_0000;
   localparam logic [31:0] TIME_RST = 32'h0000_0000;
   localparam logic [15:0] SEC_RST = 16'h0000;
   localparam logic [15:0] BCL_RST = 16'h0000;
endpackage : ident_pkg

// file: logic/ident_rd_if.sv
// Interface: word read port between the register slave and word builder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface ident_rd_if;
   logic [7:0] idx;
   logic [15:0] word;
   modport req (output idx, input word);
   modport rsp (input idx, output word);
endinterface : ident_rd_if
`default_nettype wire

// file: logic/ident_word_mux.sv
// Combinational selection of one identification word by index.
// Assumes the fields handed in are already made consistent.
`timescale 1ns/1ns
`default_nettype none
module ident_word_mux
   import ident_pkg::*;
(
   ident_rd_if.rsp rd,
   input wire logic [15:0] w0_i,
   input wire logic [15:0] w49_i,
   input wire logic [15:0] w62_i,
   input wire logic [15:0] w63_i,
   input wire logic [15:0] w71_i,
   input wire logic [15:0] w72_i,
   input wire logic [15:0] w75_i,
   input wire logic [15:0] w88_i,
   input wire logic [15:0] w125_i,
   input wire logic [15:0] w127_i,
   input wire logic [15:0] w128_i
);
   always_comb
   begin
      unique case (rd.idx)
         W_GENCFG: rd.word = w0_i;
         W_CAPS: rd.word = w49_i;
         W_DMADIR: rd.word = w62_i;
         W_MWDMA: rd.word = w63_i;
         W_PKT_REL: rd.word = w71_i;
         W_SVC_REL: rd.word = w72_i;
         W_QDEPTH: rd.word = w75_i;
         W_UDMA: rd.word = w88_i;
         W_BCL0: rd.word = w125_i;
         W_RMSN: rd.word = w127_i;
         W_SECST: rd.word = w128_i;
         // Serial number, when absent, falls here as zeros
         default: rd.word = 16'h0000;
      endcase
   end
endmodule : ident_word_mux
`default_nettype wire

// file: sim/ident_block_properties.sv
// Checker: bus timing and DMA word sanity seen at the top ports.
// Assumes one clock domain and a classic Wishbone master.
`timescale 1ns/1ns
`default_nettype none
module ident_block_properties
   import ident_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic bcl_abort_o,
   input wire logic [15:0] bcl_eff_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // Word 88 in the top half, word 63 in the low half
   sequence s_stat;
      wb_ack_o && !wb_we_i && wb_adr_i == REG_STAT;
   endsequence
   AST_ACK_NEXT: assert property (s_take |=> wb_ack_o)
      else $error("no ack one cycle after request");
   AST_ACK_CAUSE: assert property (
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o))
      else $error("ack without a taken request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   AST_ABORT_EFF: assert property (bcl_abort_o |-> bcl_eff_o == 16'h0)
      else $error("abort with nonzero limit");
   AST_MW_CUMUL: assert property (s_stat |->
      (!wb_dat_o[2] || &wb_dat_o[1:0]) && (!wb_dat_o[1] || wb_dat_o[0]))
      else $error("multiword support not cumulative");
   AST_ONE_MODE: assert property (s_stat |->
      $onehot0({wb_dat_o[10:8], wb_dat_o[30:24]}))
      else $error("more than one DMA mode selected");
   AST_RSV_ZERO: assert property (s_stat |->
      wb_dat_o[15:11] == 5'h0 && wb_dat_o[7:3] == 5'h0
      && !wb_dat_o[31] && !wb_dat_o[23])
      else $error("reserved DMA bits set");
endmodule : ident_block_properties
bind ident_block ident_block_properties chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .bcl_abort_o(bcl_abort_o), .bcl_eff_o(bcl_eff_o));
`default_nettype wire

// file: sim/host_model.sv
// Host model: classic Wishbone master fetching the identification words.
// Assumes a slave that answers within a few cycles.
`timescale 1ns/1ns
`default_nettype none
module host_model
   import ident_pkg::*;
(
   input wire logic clk_i,
   input wire logic ack_i,
   input wire logic [31:0] dat_i,
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [7:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   initial
   begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o = 1'b0;
      adr_o = 8'hff;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end
   task automatic xfer(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q, output bit ok);
      int n;
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      adr_o <= a;
      sel_o <= 4'hf;
      dat_o <= d;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_i !== 1'b1 && n < 20);
      ok = (ack_i === 1'b1);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      // Released lines must not keep looking valid
      adr_o <= ~a;
      dat_o <= ~d;
   endtask : xfer
   task automatic fetch(output logic [15:0] img [256], output bit ok);
      logic [31:0] q;
      bit k;
      xfer(REG_PTR, 1'b1, 32'h0, q, ok);
      for (int i = 0; i < 256; i++)
      begin
         xfer(REG_DATA, 1'b0, 32'h0, q, k);
         img[i] = q[15:0];
         ok &= k;
      end
   endtask : fetch
endmodule : host_model
`default_nettype wire

// file: sim/ident_block_bench.sv
// Bench: programs the block, fetches the word image and compares it.
// Assumes the host model owns the bus; one 20 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module ident_block_bench;
   import ident_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc, stb, we, ack, abort;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] dw, dr;
   logic [15:0] eff;
   logic [15:0] blk [256];
   logic [15:0] ew [256];
   bit ok;
   int err_total = 0;
   int check_count = 0;
   always #25 clk_i = ~clk_i;
   ident_block dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
      .bcl_abort_o(abort), .bcl_eff_o(eff));
   host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(dr), .cyc_o(cyc),
      .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw));
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic [7:0] a, input logic w,
      input logic [31:0] d, output logic [31:0] q);
      bit k;
      host.xfer(a, w, d, q, k);
      if (!k)
      begin
         err_total++;
         end_of_test();
      end
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(a, 1'b1, d, q);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      acc(a, 1'b0, 32'h0, q);
      chk(q, e);
   endtask : rc
   task automatic wc(input logic [7:0] i, input logic [15:0] e);
      wr(REG_PTR, {24'h0, i});
      rc(REG_DATA, {16'h0, e});
   endtask : wc
   initial
   begin
      ew = '{default: 16'h0};
      ew[0] = 16'h85c5;
      ew[49] = 16'h6b00;
      ew[63] = 16'h0007;
      ew[71] = 16'h000a;
      ew[72] = 16'h0014;
      ew[75] = 16'h0007;
      ew[88] = 16'h0107;
      ew[125] = 16'h0200;
      ew[127] = 16'h0001;
      ew[128] = 16'h013f;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk({31'h0, abort}, 32'h1);
      chk({16'h0, eff}, 32'h0);
      rc(8'h24, 32'h0);
      wr(8'h24, 32'hffff_ffff);
      wr(REG_CFG, 32'h0000_43a5);
      wr(REG_CAP, 32'h0000_074a);
      wr(REG_DMA, 32'h0005_0764);
      wr(REG_TIME, 32'h0014_000a);
      wr(REG_SEC, 32'h0000_013f);
      wr(REG_BCL, 32'h0000_0200);
      rc(REG_STAT, 32'h0107_0007);
      host.fetch(blk, ok);
      chk({31'h0, ok}, 32'h1);
      for (int i = 0; i < 256; i++)
         chk({16'h0, blk[i]}, {16'h0, ew[i]});
      chk({16'h0, blk[0]}, {16'h0, ew[0]});
      chk({16'h0, blk[49]}, {16'h0, ew[49]});
      chk({blk[72], blk[71]}, {ew[72], ew[71]});
      chk({blk[128], blk[127]}, {ew[128], ew[127]});
      chk({16'h0, blk[75]}, {16'h0, ew[75]});
      chk({abort, 15'h0, eff}, 32'h0000_0200);
      $display("test plain image done");
      wr(REG_BCL, 32'h0040_0000);
      wc(W_BCL0, 16'h0200);
      chk({abort, 15'h0, eff}, 32'h0000_0040);
      wr(REG_BCL, 32'h0000_0000);
      wc(W_BCL0, 16'h0200);
      chk({abort, 15'h0, eff}, 32'h0000_0200);
      $display("test byte limit done");
      wr(REG_CFG, 32'h0000_36d2);
      wr(REG_DMA, 32'h0000_7f07);
      wc(W_GENCFG, 16'h9f00);
      wc(W_CAPS, 16'h6e00);
      wc(W_DMADIR, 16'h87fe);
      rc(REG_STAT, 32'h0);
      $display("test direction flag done");
      end_of_test();
   end
endmodule : ident_block_bench
`default_nettype wire
